// [rtl/ccl_ctrl.sv]
`timescale 1ns/10ps
`include "ccl_map.svh"
module ccl_ctrl
  import ccl_pkg::*;
#(
  parameter int LATCHES = `CCL_LATCH_COUNT // Number of interface latches
)
(
  input wire logic ref_clk_i,              // System clock
  input wire logic srst_i,                 // Synchronous reset
  input wire logic ctl_clock_i,            // Serial shift clock
  input wire logic ctl_select_n_i,         // Chip select, active low
  input wire logic ctl_data_in_i,          // Serial data in
  output logic ctl_data_out_o,             // Serial data out
  output logic ctl_data_oe_o,              // Serial data out enable
  input wire logic [LATCHES-1:0] latch_pin_i,   // Latch pin levels
  output logic [LATCHES-1:0] latch_pin_o,       // Latch pin drive values
  output logic [LATCHES-1:0] latch_pin_oe_o,    // Latch pin drive enables
  input wire logic mclk_i,                 // Master clock, sampled
  output logic frame_tick_o,               // Pulse per frame from divider
  output ccl_mclk_t mclk_freq_sel_o,       // Divider selection
  output ccl_law_t law_o,                  // Companding law in use
  output logic nondelayed_timing_o,        // High: non-delayed timing
  output ccl_loop_t loop_mode_o,           // Loop mode
  output logic power_down_state_o,         // High while powered down
  output logic tx_analog_loop_sel_o,       // High: tx input from rx output
  output logic rx_analog_drive_o,          // Receive amplifier enable
  output logic [7:0] pos_full_scale_o,     // Positive full-scale code
  output logic [7:0] neg_full_scale_o,     // Negative full-scale code
  input wire logic [7:0] enc_word_i,       // Encoder word, uninverted
  output logic [7:0] dec_word_o,           // Word to decoder
  input wire logic tx_slot_start_i,        // Pulse: transmit slot begins
  input wire logic tx_bit_en_i,            // Pulse: next transmit bit
  input wire logic tx_slot_active_i,       // Level: transmit slot in progress
  input wire logic tx_port_sel_i,          // Transmit port: 0 or 1
  output logic pcm_tx_out0_o,              // Transmit port 0 data
  output logic pcm_tx_out0_oe_o,           // Transmit port 0 enable
  output logic pcm_tx_out1_o,              // Transmit port 1 data
  output logic pcm_tx_out1_oe_o,           // Transmit port 1 enable
  input wire logic rx_bit_en_i,            // Pulse: receive bit valid
  input wire logic rx_bit_i                // Receive serial bit
);
  ccl_state_t state;
  logic [7:0] codec_control_reg;
  logic [LATCHES-1:0] latch_direction_reg;
  logic [LATCHES-1:0] latch_content_reg;
  logic [3:0] pend_op;
  logic byte_valid;
  logic [7:0] byte_data;
  logic rd_load;
  logic [7:0] rd_data;
  logic [7:0] dir_byte;
  logic [7:0] cont_byte;
  logic [7:0] inv_mask;
  logic [9:0] div_ratio;
  logic [9:0] div_cnt;
  logic mclk_q;
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  logic [2:0] rx_cnt;
  logic [7:0] rx_pcm_reg;
  logic [7:0] next_tx_word;

  ccl_serial_port u_port (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .ctl_clock_i(ctl_clock_i),
    .ctl_select_n_i(ctl_select_n_i),
    .ctl_data_in_i(ctl_data_in_i),
    .ctl_data_out_o(ctl_data_out_o),
    .ctl_data_oe_o(ctl_data_oe_o),
    .byte_valid_o(byte_valid),
    .byte_data_o(byte_data),
    .rd_load_i(rd_load),
    .rd_data_i(rd_data)
  );

  // Instruction decode and register writes
  always_ff @(posedge ref_clk_i)
  begin
    rd_load <= 1'b0;
    if (srst_i)
    begin
      state <= CCL_ST_INSTR;
      pend_op <= 4'h0;
      rd_data <= 8'h00;
      power_down_state_o <= `CCL_PDN_RESET;
      codec_control_reg <= `CCL_CTL_RESET;
      latch_direction_reg <= LATCHES'(`CCL_LDIR_RESET);
      latch_content_reg <= LATCHES'(`CCL_LCONT_RESET);
    end
    else if (byte_valid)
    begin
      unique case (state)
        CCL_ST_INSTR:
        begin
          power_down_state_o <= byte_data[`CCL_INS_PWR_BIT];
          pend_op <= byte_data[`CCL_INS_OP_HI:`CCL_INS_OP_LO];
          if (!byte_data[`CCL_INS_TWO_BIT])
            state <= CCL_ST_INSTR;
          else if (byte_data[`CCL_INS_RD_BIT])
          begin
            state <= CCL_ST_READ;
            rd_load <= 1'b1;
            unique case (byte_data[`CCL_INS_OP_HI:`CCL_INS_OP_LO])
              `CCL_OP_CTRL: rd_data <= codec_control_reg;
              `CCL_OP_LDIR: rd_data <= dir_byte;
              `CCL_OP_LCONT: rd_data <= cont_byte;
              default: rd_data <= 8'h00;
            endcase
          end
          else
            state <= CCL_ST_WRITE;
        end
        CCL_ST_WRITE:
        begin
          state <= CCL_ST_INSTR;
          if (pend_op == `CCL_OP_CTRL)
            codec_control_reg <= byte_data;
          else if (pend_op == `CCL_OP_LDIR)
            for (int n = 0; n < LATCHES; n++)
              latch_direction_reg[n] <= byte_data[`CCL_LATCH_TOP_BIT - n];
          else if (pend_op == `CCL_OP_LCONT)
            for (int n = 0; n < LATCHES; n++)
              latch_content_reg[n] <= byte_data[`CCL_LATCH_TOP_BIT - n];
        end
        CCL_ST_READ:
          state <= CCL_ST_INSTR;
        default:
          state <= CCL_ST_INSTR;
      endcase
    end
  end

  // Latch pins and readback bytes, one slice per latch
  always_comb
  begin
    dir_byte = 8'h00;
    cont_byte = 8'h00;
    for (int n = 0; n < LATCHES; n++)
    begin
      dir_byte[`CCL_LATCH_TOP_BIT - n] = latch_direction_reg[n];
      cont_byte[`CCL_LATCH_TOP_BIT - n] = latch_direction_reg[n] ?
        latch_content_reg[n] : latch_pin_i[n];
    end
  end

  genvar g;
  generate
    for (g = 0; g < LATCHES; g++)
    begin : g_latch
      assign latch_pin_o[g] = latch_content_reg[g];
      assign latch_pin_oe_o[g] = latch_direction_reg[g];
    end
  endgenerate

  // Field decode of the control register
  always_comb
  begin
    mclk_freq_sel_o = ccl_mclk_t'(codec_control_reg[`CCL_CTL_FREQ_HI:`CCL_CTL_FREQ_LO]);
    nondelayed_timing_o = codec_control_reg[`CCL_CTL_TIMING_BIT];
    if (!codec_control_reg[`CCL_CTL_LAW_BIT])
      law_o = CCL_LAW_MU;
    else if (!codec_control_reg[`CCL_CTL_INV_BIT])
      law_o = CCL_LAW_A_INV;
    else
      law_o = CCL_LAW_A_PLAIN;
    if (codec_control_reg[`CCL_CTL_DLOOP_BIT])
      loop_mode_o = CCL_LOOP_DIGITAL;
    else if (codec_control_reg[`CCL_CTL_ALOOP_BIT])
      loop_mode_o = CCL_LOOP_ANALOG;
    else
      loop_mode_o = CCL_LOOP_NONE;
  end

  // Law-specific codeword conventions
  always_comb
  begin
    unique case (law_o)
      CCL_LAW_MU:
      begin
        inv_mask = 8'h00;
        pos_full_scale_o = `CCL_MU_POS_FS;
        neg_full_scale_o = `CCL_MU_NEG_FS;
      end
      CCL_LAW_A_INV:
      begin
        inv_mask = `CCL_ALAW_INV_MASK;
        pos_full_scale_o = `CCL_AINV_POS_FS;
        neg_full_scale_o = `CCL_AINV_NEG_FS;
      end
      default:
      begin
        inv_mask = 8'h00;
        pos_full_scale_o = `CCL_ANOINV_POS_FS;
        neg_full_scale_o = `CCL_ANOINV_NEG_FS;
      end
    endcase
  end

  // Analog paths: loop feed and receive amplifier
  assign tx_analog_loop_sel_o = (loop_mode_o == CCL_LOOP_ANALOG);
  assign rx_analog_drive_o = ~power_down_state_o |
    ~codec_control_reg[`CCL_CTL_PAMP_BIT];

  // Master clock divider to frame rate
  always_comb
  begin
    unique case (mclk_freq_sel_o)
      CCL_MCLK_512K: div_ratio = `CCL_DIV_512K;
      CCL_MCLK_1536K: div_ratio = `CCL_DIV_1536K;
      CCL_MCLK_2048K: div_ratio = `CCL_DIV_2048K;
      CCL_MCLK_4096K: div_ratio = `CCL_DIV_4096K;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    frame_tick_o <= 1'b0;
    if (srst_i)
    begin
      mclk_q <= 1'b0;
      div_cnt <= 10'h000;
    end
    else
    begin
      mclk_q <= mclk_i;
      if (mclk_i && !mclk_q)
      begin
        if (div_cnt >= div_ratio - 10'h001)
        begin
          div_cnt <= 10'h000;
          frame_tick_o <= 1'b1;
        end
        else
          div_cnt <= div_cnt + 10'h001;
      end
    end
  end

  // Receive PCM register, shifted in MSB first
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      rx_sh <= 8'h00;
      rx_cnt <= 3'h0;
      rx_pcm_reg <= 8'h00;
    end
    else if (rx_bit_en_i)
    begin
      rx_sh <= {rx_sh[6:0], rx_bit_i};
      rx_cnt <= rx_cnt + 3'h1;
      if (rx_cnt == 3'h7)
        rx_pcm_reg <= {rx_sh[6:0], rx_bit_i};
    end
  end

  // Decoding runs in every loop mode
  assign dec_word_o = rx_pcm_reg ^ inv_mask;

  // Transmit word: encoder, or receive register in digital loop
  assign next_tx_word = (loop_mode_o == CCL_LOOP_DIGITAL) ?
    rx_pcm_reg : (enc_word_i ^ inv_mask);

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      tx_sh <= 8'h00;
    else if (tx_slot_start_i)
      tx_sh <= next_tx_word;
    else if (tx_bit_en_i)
      tx_sh <= {tx_sh[6:0], 1'b0};
  end

  // Transmit outputs, only the selected port drives
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      pcm_tx_out0_o <= 1'b0;
      pcm_tx_out1_o <= 1'b0;
      pcm_tx_out0_oe_o <= 1'b0;
      pcm_tx_out1_oe_o <= 1'b0;
    end
    else
    begin
      pcm_tx_out0_o <= tx_slot_start_i ? next_tx_word[7] : tx_sh[7];
      pcm_tx_out1_o <= tx_slot_start_i ? next_tx_word[7] : tx_sh[7];
      pcm_tx_out0_oe_o <= tx_slot_active_i & ~tx_port_sel_i & ~power_down_state_o;
      pcm_tx_out1_oe_o <= tx_slot_active_i & tx_port_sel_i & ~power_down_state_o;
    end
  end
endmodule

// [common/ccl_map.svh]
`ifndef CCL_MAP_SVH
`define CCL_MAP_SVH
// Instruction byte fields
`define CCL_INS_PWR_BIT 7
`define CCL_INS_OP_HI 6
`define CCL_INS_OP_LO 3
`define CCL_INS_RD_BIT 2
`define CCL_INS_TWO_BIT 1
// Register opcodes (instruction bits 6:3)
`define CCL_OP_CTRL 4'h0
`define CCL_OP_LCONT 4'h1
`define CCL_OP_LDIR 4'h2
// Control byte fields
`define CCL_CTL_FREQ_HI 7
`define CCL_CTL_FREQ_LO 6
`define CCL_CTL_LAW_BIT 5
`define CCL_CTL_INV_BIT 4
`define CCL_CTL_TIMING_BIT 3
`define CCL_CTL_DLOOP_BIT 2
`define CCL_CTL_ALOOP_BIT 1
`define CCL_CTL_PAMP_BIT 0
// Latch fields: byte bit (7 - n) carries latch n
`define CCL_LATCH_TOP_BIT 7
`define CCL_LATCH_COUNT 6
// Reset values
`define CCL_CTL_RESET 8'h08
`define CCL_LDIR_RESET 6'h00
`define CCL_LCONT_RESET 6'h00
`define CCL_PDN_RESET 1'b1
// Serial word length
`define CCL_BYTE_BITS 4'h8
// Master clock edges per 8 kHz frame for each divider setting
`define CCL_DIV_512K 10'h040
`define CCL_DIV_1536K 10'h0C0
`define CCL_DIV_2048K 10'h100
`define CCL_DIV_4096K 10'h200
// A-law even-bit inversion mask
`define CCL_ALAW_INV_MASK 8'h55
// Full-scale codewords
`define CCL_MU_POS_FS 8'h80
`define CCL_MU_NEG_FS 8'h00
`define CCL_AINV_POS_FS 8'hAA
`define CCL_AINV_NEG_FS 8'h2A
`define CCL_ANOINV_POS_FS 8'hFF
`define CCL_ANOINV_NEG_FS 8'h7F
`endif

// [common/ccl_pkg.sv]
package ccl_pkg;
  typedef enum logic [1:0] {CCL_MCLK_512K, CCL_MCLK_1536K, CCL_MCLK_2048K, CCL_MCLK_4096K}
    ccl_mclk_t;
  typedef enum logic [1:0] {CCL_LAW_MU, CCL_LAW_A_INV, CCL_LAW_A_PLAIN} ccl_law_t;
  typedef enum logic [1:0] {CCL_LOOP_NONE, CCL_LOOP_DIGITAL, CCL_LOOP_ANALOG} ccl_loop_t;
  typedef enum logic [1:0] {CCL_ST_INSTR, CCL_ST_WRITE, CCL_ST_READ} ccl_state_t;
endpackage

// [rtl/ccl_serial_port.sv]
`timescale 1ns/10ps
`include "ccl_map.svh"
module ccl_serial_port
  import ccl_pkg::*;
(
  input wire logic ref_clk_i,        // System clock
  input wire logic srst_i,           // Synchronous reset
  input wire logic ctl_clock_i,      // Serial shift clock
  input wire logic ctl_select_n_i,   // Chip select, active low
  input wire logic ctl_data_in_i,    // Serial data in
  output logic ctl_data_out_o,       // Serial data out
  output logic ctl_data_oe_o,        // Serial data out enable
  output logic byte_valid_o,         // Pulse: byte received
  output logic [7:0] byte_data_o,    // Received byte
  input wire logic rd_load_i,        // Pulse: load readback byte
  input wire logic [7:0] rd_data_i   // Readback byte
);
  logic clk_q;
  logic [3:0] bit_cnt;
  logic [7:0] in_sh;
  logic [7:0] out_sh;
  logic rd_phase;
  logic fall_edge;
  logic rise_edge;

  // Edge detect of the shift clock in the system clock domain
  assign fall_edge = clk_q & ~ctl_clock_i & ~ctl_select_n_i;
  assign rise_edge = ~clk_q & ctl_clock_i & ~ctl_select_n_i;

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      clk_q <= 1'b0;
    else
      clk_q <= ctl_clock_i;
  end

  // Input shifting, MSB first, on falling edges
  always_ff @(posedge ref_clk_i)
  begin
    byte_valid_o <= 1'b0;
    if (srst_i || ctl_select_n_i)
    begin
      bit_cnt <= 4'h0;
      in_sh <= 8'h00;
      if (srst_i)
        byte_data_o <= 8'h00;
    end
    else if (fall_edge)
    begin
      if (bit_cnt == `CCL_BYTE_BITS - 4'h1)
      begin
        bit_cnt <= 4'h0;
        byte_data_o <= {in_sh[6:0], ctl_data_in_i};
        byte_valid_o <= 1'b1;
      end
      else
      begin
        bit_cnt <= bit_cnt + 4'h1;
        in_sh <= {in_sh[6:0], ctl_data_in_i};
      end
    end
  end

  // Readback shifting on rising edges; output floats otherwise
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      out_sh <= 8'h00;
      rd_phase <= 1'b0;
      ctl_data_out_o <= 1'b0;
      ctl_data_oe_o <= 1'b0;
    end
    else if (rd_load_i)
    begin
      out_sh <= rd_data_i;
      rd_phase <= 1'b1;
    end
    else if (ctl_select_n_i || (rd_phase && fall_edge && bit_cnt == `CCL_BYTE_BITS - 4'h1))
    begin
      rd_phase <= 1'b0;
      ctl_data_oe_o <= 1'b0;
    end
    else if (rd_phase && rise_edge)
    begin
      ctl_data_out_o <= out_sh[7];
      out_sh <= {out_sh[6:0], 1'b0};
      ctl_data_oe_o <= 1'b1;
    end
  end
endmodule

// [test/ccl_ctrl_checker.sv]
`timescale 1ns/10ps
module ccl_ctrl_checker
  import ccl_pkg::*;
#(
  parameter int LATCHES = 6 // Latch count
)
(
  input wire logic ref_clk_i, // Clock
  input wire logic srst_i, // Reset
  input wire logic ctl_select_n_i, // Select
  input wire logic ctl_data_oe_o, // Readback enable
  input wire logic [LATCHES-1:0] latch_pin_oe_o, // Latch enables
  input wire logic mclk_i, // Master clock
  input wire logic frame_tick_o, // Frame pulse
  input wire ccl_mclk_t mclk_freq_sel_o, // Divider select
  input wire ccl_law_t law_o, // Law
  input wire logic nondelayed_timing_o, // Timing
  input wire ccl_loop_t loop_mode_o, // Loop mode
  input wire logic power_down_state_o, // Power down
  input wire logic tx_analog_loop_sel_o, // Analog loop
  input wire logic rx_analog_drive_o, // Amp enable
  input wire logic [7:0] pos_full_scale_o, // Positive code
  input wire logic [7:0] neg_full_scale_o, // Negative code
  input wire logic pcm_tx_out0_oe_o, // Port 0 enable
  input wire logic pcm_tx_out1_oe_o // Port 1 enable
);
  logic mclk_q;
  logic armed;
  ccl_mclk_t sel_q;
  logic [11:0] rises;
  logic [11:0] ratio;
  logic [15:0] fs;
  assign fs = {pos_full_scale_o, neg_full_scale_o};
  // Master clock rises between frame pulses at one divider setting
  always_ff @(posedge ref_clk_i)
  begin
    mclk_q <= mclk_i;
    sel_q <= mclk_freq_sel_o;
    if (srst_i || frame_tick_o || sel_q != mclk_freq_sel_o)
      rises <= {11'h000, mclk_i & ~mclk_q};
    else
      rises <= rises + {11'h000, mclk_i & ~mclk_q};
    armed <= !srst_i && sel_q == mclk_freq_sel_o && (armed || frame_tick_o);
  end
  // Expected spacing in master clock rises
  always_comb
    case (mclk_freq_sel_o)
      CCL_MCLK_512K: ratio = 12'h040;
      CCL_MCLK_1536K: ratio = 12'h0C0;
      CCL_MCLK_2048K: ratio = 12'h100;
      default: ratio = 12'h200;
    endcase
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);
  chk_frame_ratio: assert property (frame_tick_o && armed && sel_q == mclk_freq_sel_o
    |-> rises == ratio) else $error("frame pulse spacing wrong");
  chk_fs_mu: assert property (law_o == CCL_LAW_MU |-> fs == 16'h8000)
    else $error("mu-law codes wrong");
  chk_fs_ainv: assert property (law_o == CCL_LAW_A_INV |-> fs == 16'hAA2A)
    else $error("inverted A-law codes wrong");
  chk_fs_aplain: assert property (law_o == CCL_LAW_A_PLAIN |-> fs == 16'hFF7F)
    else $error("plain A-law codes wrong");
  chk_loop_path: assert property (tx_analog_loop_sel_o == (loop_mode_o == CCL_LOOP_ANALOG))
    else $error("analog loop path wrong");
  chk_amp_powered: assert property (!power_down_state_o |-> rx_analog_drive_o)
    else $error("receive amp off while powered up");
  chk_reset_defaults: assert property ($fell(srst_i) |-> law_o == CCL_LAW_MU
    && loop_mode_o == CCL_LOOP_NONE && nondelayed_timing_o) else $error("reset defaults wrong");
  chk_latch_float: assert property ($fell(srst_i) |-> (latch_pin_oe_o == '0) [*2])
    else $error("latch driven after reset");
  chk_readback_float: assert property (ctl_select_n_i [*2] |-> !ctl_data_oe_o)
    else $error("readback driven while deselected");
  chk_port_excl: assert property (!(pcm_tx_out0_oe_o && pcm_tx_out1_oe_o))
    else $error("both transmit ports driven");
  cover property (frame_tick_o && armed);
  cover property (loop_mode_o == CCL_LOOP_DIGITAL && pcm_tx_out1_oe_o);
  cover property (ctl_data_oe_o);
endmodule
bind ccl_ctrl ccl_ctrl_checker #(.LATCHES(LATCHES)) ccl_ctrl_checker_inst (.ref_clk_i(ref_clk_i),
  .srst_i(srst_i), .ctl_select_n_i(ctl_select_n_i), .ctl_data_oe_o(ctl_data_oe_o),
  .latch_pin_oe_o(latch_pin_oe_o), .mclk_i(mclk_i), .frame_tick_o(frame_tick_o),
  .mclk_freq_sel_o(mclk_freq_sel_o), .law_o(law_o), .nondelayed_timing_o(nondelayed_timing_o),
  .loop_mode_o(loop_mode_o), .power_down_state_o(power_down_state_o),
  .tx_analog_loop_sel_o(tx_analog_loop_sel_o), .rx_analog_drive_o(rx_analog_drive_o),
  .pos_full_scale_o(pos_full_scale_o), .neg_full_scale_o(neg_full_scale_o),
  .pcm_tx_out0_oe_o(pcm_tx_out0_oe_o), .pcm_tx_out1_oe_o(pcm_tx_out1_oe_o));

// [test/ccl_host_model.sv]
`timescale 1ns/10ps
module ccl_host_model (
  input wire logic ref_clk_i, // Clock
  input wire logic ctl_data_i, // Readback bit
  output logic ctl_clock_o = 1'b0, // Shift clock
  output logic ctl_select_n_o = 1'b1, // Select, active low
  output logic ctl_data_o = 1'b0, // Serial data
  output logic rd_valid_o = 1'b0, // Pulse: readback done
  output logic [7:0] rd_byte_o = 8'h00 // Readback byte
);
  // Steps to just after a later clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // One byte MSB first; the shift clock rests low outside frames
  task automatic shift(input logic [7:0] b, input logic rd, output logic [7:0] got);
    for (int i = 7; i >= 0; i--)
    begin
      ctl_data_o = rd ? ~ctl_data_o : b[i];
      ctl_clock_o = 1'b1;
      tick(3);
      got[i] = ctl_data_i;
      ctl_clock_o = 1'b0;
      tick(3);
    end
  endtask
  // Instruction byte, then data or readback byte under one select
  task automatic xfer(input logic [7:0] b1, input logic [7:0] b2);
    logic [7:0] got;
    ctl_select_n_o = 1'b0;
    shift(b1, 1'b0, got);
    if (b1[1])
      shift(b2, b1[2], got);
    ctl_select_n_o = 1'b1;
    ctl_data_o = ~ctl_data_o; // Released line shows no stale value
    rd_byte_o = got;
    rd_valid_o = b1[1] & b1[2];
    tick(1);
    rd_valid_o = 1'b0;
    tick(2);
  endtask
endmodule

// [test/ccl_ctrl_test.sv]
`timescale 1ns/10ps
module ccl_ctrl_test;
  import ccl_pkg::*;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [1:0] mclk_div = 2'h0;
  logic [5:0] ext_pin = 6'h00;
  logic [7:0] enc_word_i = 8'h00;
  logic tx_slot_start_i = 1'b0, tx_bit_en_i = 1'b0, tx_slot_active_i = 1'b0;
  logic tx_port_sel_i = 1'b0, rx_bit_en_i = 1'b0, rx_bit_i = 1'b0;
  wire logic ctl_clock_i, ctl_select_n_i, ctl_data_in_i, mclk_i, rd_valid;
  wire logic [5:0] latch_pin_i;
  logic ctl_data_out_o, ctl_data_oe_o, frame_tick_o, nondelayed_timing_o, power_down_state_o;
  logic tx_analog_loop_sel_o, rx_analog_drive_o, pcm_tx_out0_o, pcm_tx_out0_oe_o;
  logic pcm_tx_out1_o, pcm_tx_out1_oe_o;
  logic [5:0] latch_pin_o, latch_pin_oe_o, oee, ce;
  logic [7:0] rd_byte, pos_full_scale_o, neg_full_scale_o, dec_word_o, v, w, t, dir, cont, rde;
  ccl_mclk_t mclk_freq_sel_o;
  ccl_law_t law_o;
  ccl_loop_t loop_mode_o;
  int fail_count = 0;
  int comparisons = 0;
  logic [7:0] exp_q[$];
  logic [7:0] tbl [8] = '{8'h00, 8'h5F, 8'hA4, 8'hF2, 8'h38, 8'h6A, 8'h11, 8'hC6};
  // Reference clock, master clock at a quarter rate, latch wire levels
  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) mclk_div <= mclk_div + 2'h1;
  assign mclk_i = mclk_div[1];
  assign latch_pin_i = (latch_pin_oe_o & latch_pin_o) | (~latch_pin_oe_o & ext_pin);
  ccl_ctrl ccl_ctrl_inst (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .ctl_clock_i(ctl_clock_i),
    .ctl_select_n_i(ctl_select_n_i), .ctl_data_in_i(ctl_data_in_i),
    .ctl_data_out_o(ctl_data_out_o), .ctl_data_oe_o(ctl_data_oe_o),
    .latch_pin_i(latch_pin_i), .latch_pin_o(latch_pin_o), .latch_pin_oe_o(latch_pin_oe_o),
    .mclk_i(mclk_i), .frame_tick_o(frame_tick_o), .mclk_freq_sel_o(mclk_freq_sel_o),
    .law_o(law_o), .nondelayed_timing_o(nondelayed_timing_o), .loop_mode_o(loop_mode_o),
    .power_down_state_o(power_down_state_o), .tx_analog_loop_sel_o(tx_analog_loop_sel_o),
    .rx_analog_drive_o(rx_analog_drive_o), .pos_full_scale_o(pos_full_scale_o),
    .neg_full_scale_o(neg_full_scale_o), .enc_word_i(enc_word_i), .dec_word_o(dec_word_o),
    .tx_slot_start_i(tx_slot_start_i), .tx_bit_en_i(tx_bit_en_i),
    .tx_slot_active_i(tx_slot_active_i), .tx_port_sel_i(tx_port_sel_i),
    .pcm_tx_out0_o(pcm_tx_out0_o), .pcm_tx_out0_oe_o(pcm_tx_out0_oe_o),
    .pcm_tx_out1_o(pcm_tx_out1_o), .pcm_tx_out1_oe_o(pcm_tx_out1_oe_o),
    .rx_bit_en_i(rx_bit_en_i), .rx_bit_i(rx_bit_i));
  // Readback line shows the inverse of the last bit while nothing drives it
  ccl_host_model ccl_host_model_inst (.ref_clk_i(ref_clk_i),
    .ctl_data_i(ctl_data_oe_o ? ctl_data_out_o : ~ctl_data_out_o),
    .ctl_clock_o(ctl_clock_i), .ctl_select_n_o(ctl_select_n_i), .ctl_data_o(ctl_data_in_i),
    .rd_valid_o(rd_valid), .rd_byte_o(rd_byte));
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    check("pending", 16'(exp_q.size()), 16'h0000);
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Each readback is compared with the oldest note
  always @(posedge ref_clk_i)
    if (rd_valid === 1'b1)
      check("readback", rd_byte, exp_q.size() ? exp_q.pop_front() : 8'hXX);
  // Main sequence
  initial
  begin
    void'($urandom(20354));
    enc_word_i = 8'($urandom());
    tick(2);
    srst_i = 1'b0;
    tick(1);
    check("law", law_o, CCL_LAW_MU);
    check("timing", nondelayed_timing_o, 1'b1);
    check("latch_oe", latch_pin_oe_o, 6'h00);
    exp_q.push_back(8'h08);
    ccl_host_model_inst.xfer(8'h86, 8'h00);
    repeat (2)
    begin
      for (int n = 0; n < 600 && frame_tick_o !== 1'b1; n++)
        tick(1);
      check("frame_tick", frame_tick_o, 1'b1);
      if (frame_tick_o !== 1'b1)
        give_verdict();
      tick(1);
    end
    for (int k = 0; k < 8; k++)
    begin
      v = tbl[k];
      ccl_host_model_inst.xfer(8'h02, v);
      check("mclk_sel", mclk_freq_sel_o, v[7:6]);
      check("law", law_o, v[5] ? (v[4] ? CCL_LAW_A_PLAIN : CCL_LAW_A_INV) : CCL_LAW_MU);
      check("fs", {pos_full_scale_o, neg_full_scale_o},
        v[5] ? (v[4] ? 16'hFF7F : 16'hAA2A) : 16'h8000);
      check("timing", nondelayed_timing_o, v[3]);
      check("loop", loop_mode_o,
        v[2] ? CCL_LOOP_DIGITAL : (v[1] ? CCL_LOOP_ANALOG : CCL_LOOP_NONE));
      check("aloop", tx_analog_loop_sel_o, v[2:1] == 2'b01);
      check("rx_drive", rx_analog_drive_o, 1'b1);
      exp_q.push_back(v);
      ccl_host_model_inst.xfer(8'h06, 8'h00);
    end
    // Amp state in power-down for both amp settings, then single-byte power-up
    for (int k = 0; k < 3; k++)
    begin
      ccl_host_model_inst.xfer(k < 2 ? 8'h82 : 8'h00, {7'h00, k[0]});
      check("rx_drive", rx_analog_drive_o, k != 1);
      check("pdn", power_down_state_o, k < 2);
    end
    ext_pin = 6'($urandom());
    cont = 8'($urandom()) & 8'hFC;
    dir = 8'($urandom()) & 8'hFC;
    ccl_host_model_inst.xfer(8'h0A, cont);
    ccl_host_model_inst.xfer(8'h12, dir);
    rde = 8'h00;
    for (int n = 0; n < 6; n++)
    begin
      oee[n] = dir[7 - n];
      ce[n] = cont[7 - n];
      rde[7 - n] = dir[7 - n] ? cont[7 - n] : ext_pin[n];
    end
    check("latch_oe", latch_pin_oe_o, oee);
    check("latch_out", latch_pin_o, ce);
    exp_q.push_back(rde);
    ccl_host_model_inst.xfer(8'h0E, 8'h00);
    exp_q.push_back(dir);
    ccl_host_model_inst.xfer(8'h16, 8'h00);
    exp_q.push_back(8'h00);
    ccl_host_model_inst.xfer(8'h2E, 8'h00);
    // All six latches end up as outputs
    ccl_host_model_inst.xfer(8'h12, 8'hFC);
    check("latch_oe", latch_pin_oe_o, 6'h3F);
    // Digital loop on port 1, then inverted A-law encoder path on port 0
    w = 8'($urandom());
    for (int p = 0; p < 2; p++)
    begin
      ccl_host_model_inst.xfer(8'h02, p ? 8'h20 : 8'h04);
      for (int i = 7; i >= 0; i--)
      begin
        rx_bit_i = w[i];
        rx_bit_en_i = 1'b1;
        tick(1);
        rx_bit_en_i = 1'b0;
        tick(1);
      end
      check("dec_word", dec_word_o, p ? w ^ 8'h55 : w);
      tx_port_sel_i = !p;
      tx_slot_active_i = 1'b1;
      tx_slot_start_i = 1'b1;
      tick(1);
      tx_slot_start_i = 1'b0;
      tick(1);
      for (int i = 7; i >= 0; i--)
      begin
        t[i] = p ? pcm_tx_out0_o : pcm_tx_out1_o;
        tx_bit_en_i = 1'b1;
        tick(1);
        tx_bit_en_i = 1'b0;
        tick(1);
      end
      check("tx_word", t, p ? enc_word_i ^ 8'h55 : w);
      check("tx_oe", {pcm_tx_out0_oe_o, pcm_tx_out1_oe_o}, p ? 2'b10 : 2'b01);
    end
    give_verdict();
  end
endmodule
